// ==== cmt_pkg.sv ====
// constants, field layouts and carrier types for the compare match timer
// ==========================================
// How it works
// - upper clock field picks lower overflow, prescale or sub-clock quarter
// - lower clock field picks event, prescale or sub-clock quarter
// - counter wrap sets wrap flag bit 7
// - counter equals compare sets match flag bit 6
// - wrap irq enable bit 5 gates overflow
// - clear on match bit 4 zeroes counter
// - upper half counts lower half overflows
// - lower half counts its selected clock ticks
// - sixteen bit compare against sixteen bit counter
// - enable bit 3 passes timer request on
// - pending bit 3 shows a request happened
// - upper byte first, holding byte, read latch
// - reset counter zero, compare all ones, controls zero
// - overflow needs both enables, match needs one
package cmt_pkg;
    localparam logic [15:0] CMT_ADDR_CLKSEL = 16'hFFB6;
    localparam logic [15:0] CMT_ADDR_FLAGS = 16'hFFB7;
    localparam logic [15:0] CMT_ADDR_CNT_HI = 16'hFFB8;
    localparam logic [15:0] CMT_ADDR_CNT_LO = 16'hFFB9;
    localparam logic [15:0] CMT_ADDR_CMP_HI = 16'hFFBA;
    localparam logic [15:0] CMT_ADDR_CMP_LO = 16'hFFBB;
    localparam logic [15:0] CMT_ADDR_IEN2 = 16'hFFF4;
    localparam logic [15:0] CMT_ADDR_INTERRUPT_REQUEST_TWO = 16'hFFF7;
    localparam int CMT_BIT_WRAP = 7;
    localparam int CMT_BIT_MATCH = 6;
    localparam int CMT_BIT_WRAP_IE = 5;
    localparam int CMT_BIT_CLR = 4;
    localparam int CMT_BIT_TIMER_IRQ = 3;
    localparam int CMT_UPPER_SEL_LSB = 4;
    localparam int CMT_LOWER_SEL_LSB = 0;
    localparam logic [15:0] CMT_COUNT_RESET = 16'h0000;
    localparam logic [15:0] CMT_MATCH_RESET = 16'hFFFF;
    localparam logic [7:0] CMT_BYTE_ZERO = 8'h00;
    localparam logic [7:0] CMT_BYTE_ONES = 8'hFF;
    localparam logic [2:0] CMT_SEL_PROHIBITED = 3'h3;
    localparam logic [2:0] CMT_SEL_DIV32 = 3'h4;
    localparam logic [2:0] CMT_SEL_DIV16 = 3'h5;
    localparam logic [2:0] CMT_SEL_DIV4 = 3'h6;
    localparam logic [2:0] CMT_SEL_SUB4 = 3'h7;
    localparam int CMT_PRE_DIV4_BIT = 1;
    localparam int CMT_PRE_DIV16_BIT = 3;
    localparam int CMT_PRE_DIV32_BIT = 4;
    localparam int CMT_PRE_WIDTH = 5;
    localparam int CMT_SUB_WIDTH = 2;
    // one bus access
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cmt_bus_type;
endpackage

// ==== cmt_timer.sv ====
// compare match timer: two cascaded 8-bit halves, compare, flags and request
`timescale 1ns/1ns
module cmt_timer
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire cmt_pkg::cmt_bus_type bus_i,
    output logic [7:0] rdata_o,
    input wire logic sub_clk_i,
    input wire logic event_i,
    output logic irq_o
);
    // ==========================================
    // input synchronisers and edge detect
    logic [2:0] sub_sync;
    logic [2:0] evt_sync;
    logic [cmt_pkg::CMT_SUB_WIDTH-1:0] sub_div;
    logic [cmt_pkg::CMT_PRE_WIDTH-1:0] pre;
    logic [cmt_pkg::CMT_PRE_WIDTH-1:0] pre_prev;
    wire sub_rise = sub_sync[1] & ~sub_sync[2];
    wire evt_rise = evt_sync[1] & ~evt_sync[2];
    wire sub4_tick = sub_rise & (&sub_div);

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            sub_sync <= 3'h0;
            evt_sync <= 3'h0;
        end
        else
        begin
            sub_sync <= {sub_sync[1:0], sub_clk_i};
            evt_sync <= {evt_sync[1:0], event_i};
        end
    end

    // prescaler and sub-clock quarter divider
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            pre <= '0;
            pre_prev <= '0;
            sub_div <= '0;
        end
        else
        begin
            pre <= pre + 1'b1;
            pre_prev <= pre;
            if (sub_rise)
                sub_div <= sub_div + 1'b1;
        end
    end

    // falling edge of a prescaler bit marks one divided tick
    wire div4_tick = pre_prev[cmt_pkg::CMT_PRE_DIV4_BIT] & ~pre[cmt_pkg::CMT_PRE_DIV4_BIT];
    wire div16_tick = pre_prev[cmt_pkg::CMT_PRE_DIV16_BIT] & ~pre[cmt_pkg::CMT_PRE_DIV16_BIT];
    wire div32_tick = pre_prev[cmt_pkg::CMT_PRE_DIV32_BIT] & ~pre[cmt_pkg::CMT_PRE_DIV32_BIT];

    // ==========================================
    // registers
    logic [7:0] clk_sel;
    logic wrap_flag;
    logic match_flag;
    logic wrap_irq_enable;
    logic clear_on_match;
    logic [7:0] count_upper;
    logic [7:0] count_lower;
    logic [7:0] match_upper;
    logic [7:0] match_lower;
    logic timer_irq_enable;
    logic timer_irq_pending;
    logic [7:0] write_hold;
    logic [7:0] read_hold;

    wire [2:0] upper_sel = clk_sel[cmt_pkg::CMT_UPPER_SEL_LSB +: 3];
    wire [2:0] lower_sel = clk_sel[cmt_pkg::CMT_LOWER_SEL_LSB +: 3];

    // address decode
    wire wr = bus_i.wr;
    wire rd = bus_i.rd;
    wire wr_clksel = wr && (bus_i.addr == cmt_pkg::CMT_ADDR_CLKSEL);
    wire wr_flags = wr && (bus_i.addr == cmt_pkg::CMT_ADDR_FLAGS);
    wire wr_cnt_hi = wr && (bus_i.addr == cmt_pkg::CMT_ADDR_CNT_HI);
    wire wr_cnt_lo = wr && (bus_i.addr == cmt_pkg::CMT_ADDR_CNT_LO);
    wire wr_cmp_hi = wr && (bus_i.addr == cmt_pkg::CMT_ADDR_CMP_HI);
    wire wr_cmp_lo = wr && (bus_i.addr == cmt_pkg::CMT_ADDR_CMP_LO);
    wire wr_ien2 = wr && (bus_i.addr == cmt_pkg::CMT_ADDR_IEN2);
    wire wr_interrupt_request_two = wr && (bus_i.addr == cmt_pkg::CMT_ADDR_INTERRUPT_REQUEST_TWO);
    wire rd_cnt_hi = rd && (bus_i.addr == cmt_pkg::CMT_ADDR_CNT_HI);

    // ==========================================
    // count clock selection
    // lower input select; prohibited code stops it
    wire lower_tick = (lower_sel == cmt_pkg::CMT_SEL_SUB4) ? sub4_tick :
                      (lower_sel == cmt_pkg::CMT_SEL_DIV4) ? div4_tick :
                      (lower_sel == cmt_pkg::CMT_SEL_DIV16) ? div16_tick :
                      (lower_sel == cmt_pkg::CMT_SEL_DIV32) ? div32_tick :
                      (lower_sel == cmt_pkg::CMT_SEL_PROHIBITED) ? 1'b0 : evt_rise;
    wire lower_wrap = lower_tick && (count_lower == cmt_pkg::CMT_BYTE_ONES);
    // upper input select; prohibited code stops it
    wire upper_tick = (upper_sel == cmt_pkg::CMT_SEL_SUB4) ? sub4_tick :
                      (upper_sel == cmt_pkg::CMT_SEL_DIV4) ? div4_tick :
                      (upper_sel == cmt_pkg::CMT_SEL_DIV16) ? div16_tick :
                      (upper_sel == cmt_pkg::CMT_SEL_DIV32) ? div32_tick :
                      (upper_sel == cmt_pkg::CMT_SEL_PROHIBITED) ? 1'b0 : lower_wrap;
    wire upper_wrap = upper_tick && (count_upper == cmt_pkg::CMT_BYTE_ONES);

    // full sixteen bit compare, sampled on the lower count clock
    wire equal = {count_upper, count_lower} == {match_upper, match_lower};
    wire match_evt = lower_tick && equal && !wr_cmp_lo;
    // overflow of the cascade, suppressed by a lower byte write
    wire wrap_evt = upper_wrap && !wr_cnt_lo;
    // overflow gated by wrap enable, match always pends
    wire irq_evt = match_evt || (wrap_evt && wrap_irq_enable);

    // ==========================================
    // counter halves
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            count_upper <= cmt_pkg::CMT_COUNT_RESET[15:8];
            count_lower <= cmt_pkg::CMT_COUNT_RESET[7:0];
        end
        // lower write loads upper half from holding byte, lower half from bus data
        else if (wr_cnt_lo)
        begin
            count_upper <= write_hold;
            count_lower <= bus_i.wdata;
        end
        else if (match_evt && clear_on_match)
        begin
            count_upper <= cmt_pkg::CMT_BYTE_ZERO;
            count_lower <= cmt_pkg::CMT_BYTE_ZERO;
        end
        else
        begin
            if (lower_tick)
                count_lower <= count_lower + 1'b1;
            if (upper_tick)
                count_upper <= count_upper + 1'b1;
        end
    end

    // compare registers and byte holding
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            match_upper <= cmt_pkg::CMT_MATCH_RESET[15:8];
            match_lower <= cmt_pkg::CMT_MATCH_RESET[7:0];
            write_hold <= cmt_pkg::CMT_BYTE_ZERO;
            read_hold <= cmt_pkg::CMT_BYTE_ZERO;
        end
        else
        begin
            // upper writes park in the holding byte
            if (wr_cnt_hi || wr_cmp_hi)
                write_hold <= bus_i.wdata;
            if (wr_cmp_lo)
            begin
                match_upper <= write_hold;
                match_lower <= bus_i.wdata;
            end
            // reading the upper byte latches the lower
            if (rd_cnt_hi)
                read_hold <= count_lower;
        end
    end

    // control, flags and interrupt registers
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            clk_sel <= cmt_pkg::CMT_BYTE_ZERO;
            wrap_flag <= 1'b0;
            match_flag <= 1'b0;
            wrap_irq_enable <= 1'b0;
            clear_on_match <= 1'b0;
            timer_irq_enable <= 1'b0;
            timer_irq_pending <= 1'b0;
        end
        else
        begin
            if (wr_clksel)
                clk_sel <= bus_i.wdata;
            if (wr_flags)
            begin
                wrap_irq_enable <= bus_i.wdata[cmt_pkg::CMT_BIT_WRAP_IE];
                clear_on_match <= bus_i.wdata[cmt_pkg::CMT_BIT_CLR];
            end
            if (wr_ien2)
                timer_irq_enable <= bus_i.wdata[cmt_pkg::CMT_BIT_TIMER_IRQ];
            // wrap flag set wins over a zero write
            if (wrap_evt)
                wrap_flag <= 1'b1;
            else if (wr_flags && !bus_i.wdata[cmt_pkg::CMT_BIT_WRAP])
                wrap_flag <= 1'b0;
            // match flag; cleared by writing zero
            if (match_evt)
                match_flag <= 1'b1;
            else if (wr_flags && !bus_i.wdata[cmt_pkg::CMT_BIT_MATCH])
                match_flag <= 1'b0;
            // pending flag; cleared by writing zero
            if (irq_evt)
                timer_irq_pending <= 1'b1;
            else if (wr_interrupt_request_two && !bus_i.wdata[cmt_pkg::CMT_BIT_TIMER_IRQ])
                timer_irq_pending <= 1'b0;
        end
    end

    // ==========================================
    // read data and request output
    logic [7:0] next_rdata;
    always_comb
    begin
        next_rdata = cmt_pkg::CMT_BYTE_ZERO;
        if (rd)
        begin
            unique case (bus_i.addr)
                cmt_pkg::CMT_ADDR_FLAGS:
                begin
                    next_rdata[cmt_pkg::CMT_BIT_WRAP] = wrap_flag;
                    next_rdata[cmt_pkg::CMT_BIT_MATCH] = match_flag;
                    next_rdata[cmt_pkg::CMT_BIT_WRAP_IE] = wrap_irq_enable;
                    next_rdata[cmt_pkg::CMT_BIT_CLR] = clear_on_match;
                end
                cmt_pkg::CMT_ADDR_CNT_HI: next_rdata = count_upper;
                cmt_pkg::CMT_ADDR_CNT_LO: next_rdata = read_hold;
                cmt_pkg::CMT_ADDR_CMP_HI: next_rdata = match_upper;
                cmt_pkg::CMT_ADDR_CMP_LO: next_rdata = match_lower;
                cmt_pkg::CMT_ADDR_IEN2: next_rdata[cmt_pkg::CMT_BIT_TIMER_IRQ] = timer_irq_enable;
                cmt_pkg::CMT_ADDR_INTERRUPT_REQUEST_TWO: next_rdata[cmt_pkg::CMT_BIT_TIMER_IRQ] = timer_irq_pending;
                default: next_rdata = cmt_pkg::CMT_BYTE_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            rdata_o <= cmt_pkg::CMT_BYTE_ZERO;
            irq_o <= 1'b0;
        end
        else
        begin
            rdata_o <= next_rdata;
            irq_o <= timer_irq_pending && timer_irq_enable;
        end
    end
endmodule

// ==== cmt_monitor.sv ====
// checker watching the compare match timer ports
`timescale 1ns/1ns
module cmt_monitor
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire cmt_pkg::cmt_bus_type bus_i,
    input wire logic [7:0] rdata_o,
    input wire logic sub_clk_i,
    input wire logic event_i,
    input wire logic irq_o
);
    // ==========================================
    // shadows of registers written over the bus
    logic [7:0] csel;
    logic [7:0] hold;
    logic [15:0] cmp;
    logic ien;
    wire [15:0] a = bus_i.addr;
    wire w = bus_i.wr;
    wire r = bus_i.rd;
    wire stop = csel[2:0] == 3'h3 && !csel[6];
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            csel <= 8'h00;
            cmp <= 16'hFFFF;
            ien <= 1'h0;
        end
        else if (w)
        begin
            if (a == 16'hFFB6) csel <= bus_i.wdata;
            if (a == 16'hFFBA || a == 16'hFFB8) hold <= bus_i.wdata;
            if (a == 16'hFFBB) cmp <= {hold, bus_i.wdata};
            if (a == 16'hFFF4) ien <= bus_i.wdata[3];
        end
    end
    // ==========================================
    // assertions
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_rd_cmp_hi;
        r && a == 16'hFFBA;
    endsequence
    sequence s_pend_ack;
        w && a == 16'hFFF7 && !bus_i.wdata[3] && stop && $past(stop, 4);
    endsequence
    a_clksel_reads_zero: assert property (r && a == 16'hFFB6 |=> rdata_o == 8'h00)
        else $error("write only register read nonzero");
    a_cmp_upper_read: assert property (s_rd_cmp_hi |=> rdata_o == $past(cmp[15:8]))
        else $error("compare upper read wrong");
    a_cmp_lower_read: assert property (r && a == 16'hFFBB |=> rdata_o == $past(cmp[7:0]))
        else $error("compare lower read wrong");
    a_pend_spare_zero: assert property (r && a == 16'hFFF7 |=> rdata_o[7:4] == 4'h0)
        else $error("pending register spare bits set");
    a_read_data_cause: assert property (rdata_o != 8'h00 |-> $past(r))
        else $error("read data without a read");
    a_irq_needs_enable: assert property (irq_o |-> $past(ien))
        else $error("request seen while enable off");
    a_pend_clear_drop: assert property (s_pend_ack |=> ##1 !irq_o)
        else $error("request stays after pending clear");
    a_enable_off_drop: assert property (w && a == 16'hFFF4 && !bus_i.wdata[3] |=> ##1 !irq_o)
        else $error("request stays after enable off");
    a_stopped_no_request: assert property ($rose(irq_o) && $past(ien, 2) |-> !$past(stop, 2))
        else $error("request raised while both halves stopped");
endmodule
bind cmt_timer cmt_monitor u_mon (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .sub_clk_i(sub_clk_i), .event_i(event_i), .irq_o(irq_o));

// ==== cmt_timer_tb.sv ====
// self-checking bench for the compare match timer
`timescale 1ns/1ns
module cmt_timer_tb;
    // ==========================================
    // clock, reset and pins
    logic clk_i = 1'h0;
    logic sys_rst_i = 1'h1;
    cmt_pkg::cmt_bus_type bus_i = '0;
    logic sub_clk_i = 1'h0;
    logic event_i = 1'h0;
    logic [7:0] rdata_o;
    logic irq_o;
    logic [7:0] hi;
    logic [7:0] lo;
    int errors = 0;
    int samples_checked = 0;
    always #10 clk_i = ~clk_i;
    // sub-clock pin toggles every two cycles
    always
    begin
        repeat (2) @(negedge clk_i);
        sub_clk_i = ~sub_clk_i;
    end
    cmt_timer dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus_i), .rdata_o(rdata_o),
        .sub_clk_i(sub_clk_i), .event_i(event_i), .irq_o(irq_o));
    // ==========================================
    // bus tasks and comparison
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        samples_checked++;
        if (s !== e)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_i);
        bus_i = '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
        @(negedge clk_i);
        bus_i.wr = 1'h0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge clk_i);
        bus_i = '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
        @(negedge clk_i);
        bus_i.rd = 1'h0;
        d = rdata_o;
    endtask
    task automatic rdc(input logic [15:0] a, input string n, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(n, {8'h00, d}, {8'h00, e});
    endtask
    // sixteen bit pair, upper byte first
    task automatic rd16(input logic [15:0] a, input string n, input logic [15:0] e);
        rd(a, hi);
        rd(a + 16'h0001, lo);
        chk(n, {hi, lo}, e);
    endtask
    task automatic wr16(input logic [15:0] a, input logic [15:0] v);
        wr(a, v[15:8]);
        wr(a + 16'h0001, v[7:0]);
    endtask
    // count from FFF0 on the fast prescale tap
    task automatic ovf_run(input logic [7:0] f, input logic [15:0] m);
        wr(16'hFFB6, 8'h33);
        wr16(16'hFFB8, 16'hFFF0);
        wr16(16'hFFBA, m);
        wr(16'hFFB7, f);
        wr(16'hFFB6, 8'h06);
        repeat (150) @(negedge clk_i);
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // watchdog cuts a hang short
    initial
    begin
        repeat (20000) @(posedge clk_i);
        errors++;
        final_report();
    end
    // ==========================================
    // test sequence
    initial
    begin
        repeat (2) @(negedge clk_i);
        sys_rst_i = 1'h0;
        rd16(16'hFFB8, "count", 16'h0000);
        rd16(16'hFFBA, "match", 16'hFFFF);
        rdc(16'hFFB7, "flags", 8'h00);
        rdc(16'hFFB6, "clock select", 8'h00);
        for (int c = 0; c < 8; c++)
        begin
            wr(16'hFFB6, 8'h33);
            wr16(16'hFFB8, 16'h00FE);
            wr(16'hFFB6, 8'(c * 17));
            repeat (3)
            begin
                @(negedge clk_i);
                event_i = 1'h1;
                repeat (3) @(negedge clk_i);
                event_i = 1'h0;
                repeat (3) @(negedge clk_i);
            end
            repeat (100) @(negedge clk_i);
            wr(16'hFFB6, 8'h33);
            rd(16'hFFB8, hi);
            rd(16'hFFB9, lo);
            if (c < 3)
                chk("event count", {hi, lo}, 16'h0101);
            else if (c == 3)
                chk("stopped count", {hi, lo}, 16'h00FE);
            else
            begin
                chk("clocked", {14'h0000, hi != 8'h00, lo != 8'hFE}, 16'h0003);
                chk("halves in step", {8'h00, lo}, {8'h00, hi + 8'hFE});
            end
        end
        wr16(16'hFFB8, 16'h0000);
        wr(16'hFFF4, 8'h08);
        wr16(16'hFFBA, 16'h0005);
        wr(16'hFFB7, 8'h30);
        wr(16'hFFB6, 8'h07);
        for (int i = 0; i < 400 && irq_o !== 1'h1; i++) @(negedge clk_i);
        wr(16'hFFB6, 8'h33);
        chk("irq", {15'h0000, irq_o}, 16'h0001);
        rd16(16'hFFB8, "cleared count", 16'h0000);
        rd16(16'hFFBA, "match", 16'h0005);
        rdc(16'hFFB7, "flags", 8'h70);
        rdc(16'hFFF7, "pending", 8'h08);
        wr(16'hFFF7, 8'h00);
        wr(16'hFFB7, 8'h30);
        @(negedge clk_i);
        chk("irq", {15'h0000, irq_o}, 16'h0000);
        rdc(16'hFFB7, "flags", 8'h30);
        ovf_run(8'h00, 16'h8000);
        chk("irq", {15'h0000, irq_o}, 16'h0000);
        rdc(16'hFFB7, "flags", 8'h80);
        // overflow and match, no clear on match
        ovf_run(8'h20, 16'h0003);
        chk("irq", {15'h0000, irq_o}, 16'h0001);
        wr(16'hFFB6, 8'h33);
        rdc(16'hFFB7, "flags", 8'hE0);
        rd(16'hFFB8, hi);
        rd(16'hFFB9, lo);
        chk("kept counting", {15'h0000, hi == 8'h00 && lo > 8'h03}, 16'h0001);
        wr(16'hFFF4, 8'h00);
        @(negedge clk_i);
        chk("irq", {15'h0000, irq_o}, 16'h0000);
        rdc(16'hFFF7, "pending", 8'h08);
        final_report();
    end
endmodule
